// File: rtl/rrsx_map.svh
`ifndef RRSX_MAP_SVH
`define RRSX_MAP_SVH
// opcode fields (upper bits of the 16-bit program word)
`define RRSX_OPC_RRNC 6'h10
`define RRSX_OPC_FILL 7'h34
`define RRSX_FILL_VALUE 8'hff
`define RRSX_ILO_MAX 8'h5f
`define RRSX_BIT_D 9
`define RRSX_BIT_A 8
`define RRSX_ACCESS_HI_BASE 8'h60
`define RRSX_ACCESS_HI_BANK 4'hf
`define RRSX_WREG_RESET 8'h00
`endif

// File: rtl/rrsx_pkg.sv
package rrsx_pkg;
    typedef enum logic [3:0] {
        RRSX_Q1 = 4'b0001,
        RRSX_Q2 = 4'b0010,
        RRSX_Q3 = 4'b0100,
        RRSX_Q4 = 4'b1000
    } rrsx_phase_type;

    // data memory request to the register file
    typedef struct packed {
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } rrsx_mem_req_type;

    // status flag update
    typedef struct packed {
        logic upd;
        logic neg;
        logic zero;
    } rrsx_flag_type;
endpackage

// File: rtl/rrsx_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "rrsx_map.svh"
module rrsx_addr_gen (
    input wire logic [7:0] f_addr,
    input wire logic acc_sel,
    input wire logic ext_enable,
    input wire logic [3:0] bank_select_register,
    input wire logic [11:0] index_base,
    output logic [11:0] eff_addr,
    output logic indexed
);
    logic [11:0] sum;

    // effective address by mode
    always_comb begin
        sum = index_base + {4'h0, f_addr};
        indexed = !acc_sel && ext_enable && (f_addr <= `RRSX_ILO_MAX);
        if (indexed) begin
            eff_addr = sum;
        end else if (acc_sel) begin
            eff_addr = {bank_select_register, f_addr};
        end else if (f_addr >= `RRSX_ACCESS_HI_BASE) begin
            eff_addr = {`RRSX_ACCESS_HI_BANK, f_addr};
        end else begin
            eff_addr = {4'h0, f_addr};
        end
    end
endmodule
`default_nettype wire

// File: rtl/rrsx_exec.sv
// Function
// - rotate right, bit0 to bit7, N Z
// - d=0 writes working register, d=1 memory
// - a=0 access bank, a=1 uses bank select
// - a=0, extended, f<=95: indexed literal offset
// - fill opcode writes ffh, flags untouched
`timescale 1ns/1ps
`default_nettype none
`include "rrsx_map.svh"
module rrsx_exec
    import rrsx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic ext_enable,
    input wire logic [3:0] bank_select_register,
    input wire logic [11:0] index_base,
    input wire logic [7:0] mem_rdata,
    output rrsx_pkg::rrsx_mem_req_type mem_req,
    output rrsx_pkg::rrsx_flag_type flags,
    output logic [7:0] wreg,
    output logic [3:0] phase,
    output logic busy,
    output logic done
);
    import rrsx_pkg::*;

    // phase register, one-hot, q1 idles until a word is offered
    rrsx_phase_type state;
    rrsx_phase_type next_state;
    logic [15:0] ir;
    logic [15:0] next_ir;
    logic is_rot;
    logic next_is_rot;
    logic is_fill;
    logic next_is_fill;
    logic [11:0] addr;
    logic [11:0] next_addr;
    logic [7:0] data;
    logic [7:0] next_data;
    logic [7:0] next_wreg;
    rrsx_mem_req_type next_mem_req;
    rrsx_flag_type next_flags;
    logic next_done;
    logic [11:0] eff_addr;
    logic ilo_mode;

    ////////////////////////////////////////////////////////////
    // address formation
    rrsx_addr_gen rrsx_addr_gen_inst (
        .f_addr(ir[7:0]),
        .acc_sel(ir[`RRSX_BIT_A]),
        .ext_enable(ext_enable),
        .bank_select_register(bank_select_register),
        .index_base(index_base),
        .eff_addr(eff_addr),
        .indexed(ilo_mode)
    );

    ////////////////////////////////////////////////////////////
    // quarter-phase sequencer, next phase
    // every word takes four phases, unknown opcodes too
    always_comb begin
        next_state = state;
        case (state)
            RRSX_Q1: begin
                if (instr_valid) begin
                    next_state = RRSX_Q2;
                end
            end
            RRSX_Q2: begin
                next_state = RRSX_Q3;
            end
            RRSX_Q3: begin
                next_state = RRSX_Q4;
            end
            RRSX_Q4: begin
                next_state = RRSX_Q1;
            end
            default: begin
                next_state = RRSX_Q1;
            end
        endcase
    end

    // register phase
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= RRSX_Q1;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////
    // decode: take the word in q1 only
    // words offered while busy are dropped without notice
    always_comb begin
        next_ir = ir;
        next_is_rot = is_rot;
        next_is_fill = is_fill;
        if (state == RRSX_Q1 && instr_valid) begin
            next_ir = instr;
            next_is_rot = (instr[15:10] == `RRSX_OPC_RRNC);
            next_is_fill = (instr[15:9] == `RRSX_OPC_FILL);
        end
    end

    // register decoded word
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir <= 16'h0000;
            is_rot <= 1'b0;
            is_fill <= 1'b0;
        end else begin
            ir <= next_ir;
            is_rot <= next_is_rot;
            is_fill <= next_is_fill;
        end
    end

    ////////////////////////////////////////////////////////////
    // address kept from q2, result byte formed in q3
    // the address is held so bank changes after q2 cannot move the write
    always_comb begin
        next_addr = addr;
        next_data = data;
        if (state == RRSX_Q2) begin
            next_addr = eff_addr;
        end else if (state == RRSX_Q3) begin
            if (is_rot) begin
                next_data = {mem_rdata[0], mem_rdata[7:1]};
            end else begin
                next_data = `RRSX_FILL_VALUE;
            end
        end
    end

    // register address and result
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr <= 12'h000;
            data <= 8'h00;
        end else begin
            addr <= next_addr;
            data <= next_data;
        end
    end

    ////////////////////////////////////////////////////////////
    // outputs: set in q2 and q4 but registered, so read strobe shows in q3, write, flags and done in the next q1
    // strobes are single-cycle pulses, wreg holds its value
    always_comb begin
        next_wreg = wreg;
        next_mem_req = '0;
        next_flags = '0;
        next_done = 1'b0;
        case (state)
            RRSX_Q2: begin
                // fill reads too, so all phases look alike
                next_mem_req.addr = eff_addr;
                next_mem_req.rd = is_rot | is_fill;
            end
            RRSX_Q4: begin
                next_done = 1'b1;
                if (is_rot) begin
                    next_flags.upd = 1'b1;
                    next_flags.neg = data[7];
                    next_flags.zero = (data == 8'h00);
                    if (ir[`RRSX_BIT_D]) begin
                        next_mem_req.addr = addr;
                        next_mem_req.wr = 1'b1;
                        next_mem_req.wdata = data;
                    end else begin
                        next_wreg = data;
                    end
                end else if (is_fill) begin
                    // no flag pulse for fill
                    next_mem_req.addr = addr;
                    next_mem_req.wr = 1'b1;
                    next_mem_req.wdata = data;
                end
            end
            default: begin
                next_mem_req = '0;
            end
        endcase
    end

    // register outputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wreg <= `RRSX_WREG_RESET;
            mem_req <= '0;
            flags <= '0;
            done <= 1'b0;
        end else begin
            wreg <= next_wreg;
            mem_req <= next_mem_req;
            flags <= next_flags;
            done <= next_done;
        end
    end

    // phase and busy views
    assign phase = state;
    assign busy = (state != RRSX_Q1);
endmodule
`default_nettype wire

// File: verification/rrsx_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rrsx_exec_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic ext_enable,
    input wire logic [3:0] bank_select_register,
    input wire logic [11:0] index_base,
    input wire logic [7:0] mem_rdata,
    input wire rrsx_pkg::rrsx_mem_req_type mem_req,
    input wire rrsx_pkg::rrsx_flag_type flags,
    input wire logic [7:0] wreg,
    input wire logic [3:0] phase,
    input wire logic done
);
import rrsx_pkg::*;
logic [15:0] op;
logic [7:0] rd_data;
logic [15:0] next_op;
logic [7:0] next_rd_data;
wire logic [7:0] rot = {rd_data[0], rd_data[7:1]};
wire logic rr = op[15:10] == 6'h10;
wire logic fill = op[15:9] == 7'h34;
wire logic ilo = !op[8] && ext_enable && op[7:0] <= 8'h5f;
////////////////////////////////////////////////////////////////////////
// hold taken word and read data
always_comb begin
    next_op = (phase == 4'h1 && instr_valid) ? instr : op;
    next_rd_data = mem_req.rd ? mem_rdata : rd_data;
end
always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        op <= 16'h0000;
        rd_data <= 8'h00;
    end else begin
        op <= next_op;
        rd_data <= next_rd_data;
    end
end
////////////////////////////////////////////////////////////////////////
// checks
default clocking @(posedge ref_clk); endclocking
default disable iff (!reset_n);
AST_PHASE: assert property (phase == 4'h2 |=> phase == 4'h4 ##1 phase == 4'h8 ##1 phase == 4'h1)
    else $error("phase order broken");
AST_DONE: assert property (done |-> phase == 4'h1 && $past(phase) == 4'h8)
    else $error("done off phase");
AST_ROT_W: assert property (
    done && rr && !op[9] |-> wreg == rot && flags == {1'b1, rot[7], rot == 8'h00})
    else $error("rotate to working register wrong");
AST_ROT_F: assert property (
    done && rr && op[9] |-> mem_req.wr && mem_req.wdata == rot && flags.upd)
    else $error("rotate to memory wrong");
AST_FILL: assert property (
    done && fill |-> mem_req.wr && mem_req.wdata == 8'hff && !flags.upd && $stable(wreg))
    else $error("fill wrong");
AST_BANK: assert property (
    mem_req.rd && (rr || fill) && op[8] |-> mem_req.addr == {bank_select_register, op[7:0]})
    else $error("banked address wrong");
AST_ACC: assert property (
    mem_req.rd && (rr || fill) && !op[8] && !ilo
    |-> mem_req.addr == {(op[7:0] >= 8'h60) ? 4'hf : 4'h0, op[7:0]})
    else $error("access bank address wrong");
AST_IDX: assert property (
    mem_req.rd && (rr || fill) && ilo |-> mem_req.addr == index_base + op[7:0])
    else $error("indexed address wrong");
cover property (done && rr && !op[9]);
cover property (done && rr && op[9]);
cover property (done && fill);
endmodule
bind rrsx_exec rrsx_exec_checker rrsx_exec_checker_inst (.ref_clk, .reset_n, .instr, .instr_valid,
    .ext_enable, .bank_select_register, .index_base, .mem_rdata, .mem_req, .flags, .wreg, .phase, .done);
`default_nettype wire

// File: verification/rotate_right_and_set_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rotate_right_and_set_exec_tb_top;
import rrsx_pkg::*;
logic ref_clk;
logic reset_n;
logic [15:0] instr;
logic instr_valid;
logic ext_enable;
logic [3:0] bank_select_register;
logic [11:0] index_base;
logic [7:0] mem_rdata;
rrsx_mem_req_type mem_req;
rrsx_flag_type flags;
logic [7:0] wreg;
logic [3:0] phase;
logic busy;
logic done;
logic [11:0] ad;
int n_fail;
int compares;
rrsx_exec rrsx_exec_inst (.ref_clk, .reset_n, .instr, .instr_valid, .ext_enable,
    .bank_select_register, .index_base, .mem_rdata, .mem_req, .flags, .wreg, .phase, .busy, .done);
////////////////////////////////////////////////////////////////////////
// clock and watchdog
initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
end
initial begin
    #2000;
    n_fail++;
    conclude;
end
////////////////////////////////////////////////////////////////////////
// shared helpers
task automatic chk(input logic [11:0] g, input logic [11:0] e);
    compares++;
    if (g !== e) begin
        n_fail++;
        $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
endtask
task automatic run(input logic [15:0] w, input logic [7:0] d, input logic e, input logic [3:0] b);
    ad = 'x;
    instr = w;
    instr_valid = 1'b1;
    mem_rdata = d;
    ext_enable = e;
    bank_select_register = b;
    @(posedge ref_clk);
    #1 instr_valid = 1'b0;
    chk({busy, phase}, 12'h012);
    for (int i = 0; i < 8 && done !== 1'b1; i++) begin
        @(posedge ref_clk);
        #1;
        if (mem_req.rd === 1'b1) ad = mem_req.addr;
    end
    chk(done, 12'h001);
    chk({busy, phase}, 12'h001);
endtask
task conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
// scenarios
task t_rot_w;
    run(16'h4120, 8'hd7, 1'h0, 4'h3);
    chk(ad, 12'h320);
    chk(wreg, 12'h0eb);
    chk(flags, 12'h006);
    $display("rotate to working register done");
endtask
task t_rot_f;
    run(16'h4280, 8'h00, 1'h0, 4'h3);
    chk(ad, 12'hf80);
    chk({mem_req.wr, flags, mem_req.wdata}, 12'hd00);
    chk(wreg, 12'h0eb);
    $display("rotate to memory done");
endtask
task t_fill;
    index_base = 12'h100;
    run(16'h685f, 8'h5a, 1'h1, 4'h3);
    chk(ad, 12'h15f);
    chk({mem_req.wr, flags.upd, mem_req.wdata}, 12'h2ff);
    run(16'h6860, 8'h5a, 1'h1, 4'h3);
    chk(ad, 12'hf60);
    chk(wreg, 12'h0eb);
    $display("fill done");
endtask
////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
    reset_n = 1'b0;
    instr = 16'h0000;
    instr_valid = 1'b0;
    ext_enable = 1'b0;
    bank_select_register = 4'h0;
    index_base = 12'h000;
    mem_rdata = 8'h00;
    n_fail = 0;
    compares = 0;
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    t_rot_w;
    t_rot_f;
    t_fill;
    conclude;
end
endmodule
`default_nettype wire
